// file: logic/dtg_pkg.sv
// shared constants and carrier types of the dual tone generator
package dtg_pkg;

  // ************************************************************
  // register map and field layout
  // ************************************************************
  localparam int unsigned DTG_ADDR_W = 8;
  localparam logic [7:0] DTG_TONE_SEL_OFS = 8'h19;
  localparam logic [7:0] DTG_TONE_CTL_OFS = 8'h1a;
  localparam logic [7:0] DTG_OSC_SEL1_OFS = 8'h29;
  localparam logic [7:0] DTG_OSC_SEL2_OFS = 8'h2a;
  localparam logic [7:0] DTG_STATUS_OFS = 8'h30;

  localparam logic [3:0] DTG_TONE_SEL_RST = 4'h0;
  localparam logic [3:0] DTG_TONE_CTL_RST = 4'h0;
  localparam logic [3:0] DTG_OSC_SEL_RST = 4'h0;
  localparam logic [3:0] DTG_RDATA_IDLE = 4'h0;

  localparam int unsigned DTG_COL_GATE_BIT = 3;
  localparam int unsigned DTG_ROW_GATE_BIT = 2;
  localparam int unsigned DTG_MASTER_EN_BIT = 1;
  localparam int unsigned DTG_SUB_OSC_STOP_BIT = 3;
  // used bits of the control register, lowest bit is unused
  localparam logic [3:0] DTG_TONE_CTL_MASK = 4'he;

  // ************************************************************
  // oscillator codes and reference division ratios
  // ************************************************************
  localparam logic [3:0] DTG_OSC_400K = 4'h0;
  localparam logic [3:0] DTG_OSC_800K = 4'h1;
  localparam logic [3:0] DTG_OSC_2M = 4'h2;
  localparam logic [3:0] DTG_OSC_4M = 4'h3;
  localparam logic [3:0] DTG_OSC_8M = 4'hb;
  // 3.58 MHz is 01xx, 7.16 MHz is 11xx; 10xx matches no oscillator (except 1011)
  localparam int unsigned DTG_RATIO_W = 5;
  localparam logic [4:0] DTG_DIV_400K = 5'h01;
  localparam logic [4:0] DTG_DIV_800K = 5'h02;
  localparam logic [4:0] DTG_DIV_2M = 5'h05;
  localparam logic [4:0] DTG_DIV_358M = 5'h09;
  localparam logic [4:0] DTG_DIV_4M = 5'h0a;
  localparam logic [4:0] DTG_DIV_716M = 5'h12;
  localparam logic [4:0] DTG_DIV_8M = 5'h14;

  // ************************************************************
  // tone synthesis
  // ************************************************************
  // step periods in sixteenths of a reference tick, index = tone code
  localparam int unsigned DTG_PER_W = 10;
  localparam logic [9:0] DTG_ACC_INC = 10'h010;
  localparam logic [3:0][9:0] DTG_ROW_PER = {10'h0d5, 10'h0eb, 10'h104, 10'h120};
  localparam logic [3:0][9:0] DTG_COL_PER = {10'h07a, 10'h087, 10'h096, 10'h0a5};
  localparam int unsigned DTG_STEPS = 32;
  localparam int unsigned DTG_STEP_W = 5;
  localparam int unsigned DTG_AMP_W = 4;
  localparam logic [3:0] DTG_AMP_IDLE = 4'h8;
  localparam logic [31:0][3:0] DTG_SINE = {
    4'h6, 4'h5, 4'h3, 4'h2, 4'h1, 4'h1, 4'h0, 4'h0,
    4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6,
    4'h8, 4'h9, 4'ha, 4'hc, 4'hd, 4'he, 4'he, 4'hf,
    4'hf, 4'hf, 4'he, 4'he, 4'hd, 4'hc, 4'ha, 4'h9};
  // entry 0 is the last in the list above; entry 0 = 4'h9 ... see table order
  localparam logic [3:0] DTG_SINE_START = 4'h8;

  // ************************************************************
  // carrier types
  // ************************************************************
  typedef struct packed {
    logic run;
    logic gate;
    logic [9:0] period;
  } dtg_chan_cfg_t;

  typedef struct packed {
    logic [4:0] cnt;
    logic tick;
  } dtg_ref_st_t;

  typedef struct packed {
    logic [9:0] acc;
    logic [4:0] step;
    logic [3:0] amp;
  } dtg_chan_st_t;

  typedef struct packed {
    logic [3:0] tone_sel;
    logic [3:0] tone_ctl;
    logic [3:0] osc_sel1;
    logic [3:0] osc_sel2;
    logic [3:0] rdata;
  } dtg_top_st_t;

endpackage

// file: logic/dtg_ref_div.sv
// reference tick divider from the oscillator tick
`timescale 1ns/100ps

module dtg_ref_div #(
  parameter int unsigned RATIO_W = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hold,
  input wire logic osc_tick,
  input wire logic [RATIO_W-1:0] ratio,
  output logic ref_tick
);

  generate
    if (RATIO_W != dtg_pkg::DTG_RATIO_W)
    begin : g_bad_width
      $error("dtg_ref_div: ratio width must match the division table");
    end
  endgenerate

  dtg_pkg::dtg_ref_st_t st_r;
  dtg_pkg::dtg_ref_st_t st_nxt;

  // ************************************************************
  // division: one tick per 'ratio' oscillator ticks
  // ************************************************************
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (hold)
    begin
      // stopped generator keeps a known phase for the next start
      st_nxt.cnt = '0;
    end
    else if (osc_tick)
    begin
      if (st_r.cnt + 5'h01 >= ratio)
      begin
        st_nxt.cnt = '0;
        st_nxt.tick = 1'b1;
      end
      else
      begin
        st_nxt.cnt = st_r.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  assign ref_tick = st_r.tick;

endmodule

// file: logic/dtg_tone_chan.sv
// one tone channel: fractional step divider, 32 step sine counter, ladder code
`timescale 1ns/100ps

module dtg_tone_chan #(
  parameter int unsigned AMP_W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic ref_tick,
  input dtg_pkg::dtg_chan_cfg_t cfg,
  output logic [AMP_W-1:0] amp,
  output logic [4:0] step
);

  generate
    if (AMP_W != dtg_pkg::DTG_AMP_W)
    begin : g_bad_width
      $error("dtg_tone_chan: amplitude width must match the sine table");
    end
  endgenerate

  dtg_pkg::dtg_chan_st_t st_r;
  dtg_pkg::dtg_chan_st_t st_nxt;
  logic [9:0] acc_sum;

  // ************************************************************
  // step divider and sine counter
  // ************************************************************
  // the accumulator keeps the remainder, so the mean step rate is exact
  // while single steps jitter by one reference tick
  always_comb
  begin
    st_nxt = st_r;
    acc_sum = st_r.acc + dtg_pkg::DTG_ACC_INC;
    if (!cfg.run)
    begin
      st_nxt.acc = '0;
      st_nxt.step = '0;
    end
    else if (ref_tick)
    begin
      if (acc_sum >= cfg.period)
      begin
        st_nxt.acc = acc_sum - cfg.period;
        st_nxt.step = st_r.step + 5'h01;
      end
      else
      begin
        st_nxt.acc = acc_sum;
      end
    end
    if (cfg.run && cfg.gate)
    begin
      st_nxt.amp = dtg_pkg::DTG_SINE[st_nxt.step];
    end
    else
    begin
      st_nxt.amp = dtg_pkg::DTG_AMP_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '{acc: '0, step: '0, amp: dtg_pkg::DTG_AMP_IDLE};
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  assign amp = st_r.amp;
  assign step = st_r.step;

endmodule

// file: logic/dtg_top.sv
// dual tone generator: registers, reference selection and two tone channels
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps

module dtg_top #(
  parameter int unsigned ADDR_W = dtg_pkg::DTG_ADDR_W
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic OSC_TICK,
  input wire logic STOP_ENTRY,
  input wire logic WATCH_ENTRY,
  input wire logic SUBACTIVE_ENTRY,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [3:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [3:0] RDATA,
  output logic [3:0] ROW_TONE_OUT,
  output logic [3:0] COLUMN_TONE_OUT
);

  generate
    if (ADDR_W < 6)
    begin : g_bad_addr
      $error("dtg_top: address too narrow for the register map");
    end
  endgenerate

  dtg_pkg::dtg_top_st_t st_r;
  dtg_pkg::dtg_top_st_t st_nxt;
  logic [7:0] addr8;
  logic [3:0] osc_code;
  logic [4:0] ratio;
  logic master_en;
  logic ref_tick;
  logic osc_known;
  dtg_pkg::dtg_chan_cfg_t row_cfg;
  dtg_pkg::dtg_chan_cfg_t col_cfg;

  assign addr8 = 8'(ADDR);

  // ************************************************************
  // register writes, low-power clears, read port
  // ************************************************************
  // a low-power entry in the same cycle as a write wins: the mode
  // change must leave the generator silent
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rdata = dtg_pkg::DTG_RDATA_IDLE;
    if (WR)
    begin
      case (addr8)
        dtg_pkg::DTG_TONE_SEL_OFS: st_nxt.tone_sel = WDATA;
        dtg_pkg::DTG_TONE_CTL_OFS: st_nxt.tone_ctl = WDATA & dtg_pkg::DTG_TONE_CTL_MASK;
        dtg_pkg::DTG_OSC_SEL1_OFS: st_nxt.osc_sel1 = WDATA;
        dtg_pkg::DTG_OSC_SEL2_OFS: st_nxt.osc_sel2 = WDATA;
        default: st_nxt.tone_sel = st_r.tone_sel;
      endcase
    end
    if (RD && addr8 == dtg_pkg::DTG_STATUS_OFS)
    begin
      // write-only registers and unmapped addresses read as zero
      st_nxt.rdata = {col_cfg.run & col_cfg.gate, row_cfg.run & row_cfg.gate,
                      master_en, osc_known};
    end
    if (STOP_ENTRY || WATCH_ENTRY || SUBACTIVE_ENTRY)
    begin
      st_nxt.tone_sel = dtg_pkg::DTG_TONE_SEL_RST;
      st_nxt.tone_ctl = dtg_pkg::DTG_TONE_CTL_RST;
    end
    if (STOP_ENTRY)
    begin
      st_nxt.osc_sel1 = dtg_pkg::DTG_OSC_SEL_RST;
      st_nxt.osc_sel1[dtg_pkg::DTG_SUB_OSC_STOP_BIT] =
        st_r.osc_sel1[dtg_pkg::DTG_SUB_OSC_STOP_BIT];
      st_nxt.osc_sel2 = dtg_pkg::DTG_OSC_SEL_RST;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      st_r <= '{tone_sel: dtg_pkg::DTG_TONE_SEL_RST, tone_ctl: dtg_pkg::DTG_TONE_CTL_RST,
                osc_sel1: dtg_pkg::DTG_OSC_SEL_RST, osc_sel2: dtg_pkg::DTG_OSC_SEL_RST,
                rdata: dtg_pkg::DTG_RDATA_IDLE};
    end
    else if (CLK_EN)
    begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // oscillator code to reference ratio
  // ************************************************************
  // a code that matches no oscillator still yields some ratio; the tones
  // are then off frequency, which software must avoid
  assign osc_code = {st_r.osc_sel2[3:2], st_r.osc_sel1[1:0]};

  always_comb
  begin
    osc_known = 1'b1;
    casez (osc_code)
      dtg_pkg::DTG_OSC_400K: ratio = dtg_pkg::DTG_DIV_400K;
      dtg_pkg::DTG_OSC_800K: ratio = dtg_pkg::DTG_DIV_800K;
      dtg_pkg::DTG_OSC_2M: ratio = dtg_pkg::DTG_DIV_2M;
      dtg_pkg::DTG_OSC_4M: ratio = dtg_pkg::DTG_DIV_4M;
      dtg_pkg::DTG_OSC_8M: ratio = dtg_pkg::DTG_DIV_8M;
      4'b01??: ratio = dtg_pkg::DTG_DIV_358M;
      4'b11??: ratio = dtg_pkg::DTG_DIV_716M;
      default:
      begin
        ratio = dtg_pkg::DTG_DIV_8M;
        osc_known = 1'b0;
      end
    endcase
  end

  assign master_en = st_r.tone_ctl[dtg_pkg::DTG_MASTER_EN_BIT];

  dtg_ref_div #(
    .RATIO_W(dtg_pkg::DTG_RATIO_W)
  ) u_ref_div (
    .clk(CLK),
    .rst_n(RESET_N),
    .ce(CLK_EN),
    .hold(!master_en),
    .osc_tick(OSC_TICK),
    .ratio(ratio),
    .ref_tick(ref_tick)
  );

  // ************************************************************
  // row and column channels
  // ************************************************************
  always_comb
  begin
    row_cfg.run = master_en;
    row_cfg.gate = st_r.tone_ctl[dtg_pkg::DTG_ROW_GATE_BIT];
    row_cfg.period = dtg_pkg::DTG_ROW_PER[st_r.tone_sel[1:0]];
    col_cfg.run = master_en;
    col_cfg.gate = st_r.tone_ctl[dtg_pkg::DTG_COL_GATE_BIT];
    col_cfg.period = dtg_pkg::DTG_COL_PER[st_r.tone_sel[3:2]];
  end

  dtg_tone_chan #(
    .AMP_W(dtg_pkg::DTG_AMP_W)
  ) u_row (
    .clk(CLK),
    .rst_n(RESET_N),
    .ce(CLK_EN),
    .ref_tick(ref_tick),
    .cfg(row_cfg),
    .amp(ROW_TONE_OUT),
    .step()
  );

  dtg_tone_chan #(
    .AMP_W(dtg_pkg::DTG_AMP_W)
  ) u_col (
    .clk(CLK),
    .rst_n(RESET_N),
    .ce(CLK_EN),
    .ref_tick(ref_tick),
    .cfg(col_cfg),
    .amp(COLUMN_TONE_OUT),
    .step()
  );

  assign RDATA = st_r.rdata;

endmodule

// file: sim/dtg_line_rx.sv
// line side receiver that flags each wrap of the received sine from its last step into step zero
`timescale 1ns/100ps
module dtg_line_rx (
  input wire logic clk,
  input wire logic [3:0] tone,
  output logic wrap
);
  logic [3:0] prev_r;
  always_ff @(posedge clk)
  begin
    prev_r <= tone;
  end
  // last step (6) into step zero (9) happens once per period only
  assign wrap = prev_r == 4'h6 && tone == 4'h9;
endmodule

// file: sim/dtg_top_props.sv
// concurrent checks on the ports of the dual tone generator top
`timescale 1ns/100ps
module dtg_top_props #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic OSC_TICK,
  input wire logic STOP_ENTRY,
  input wire logic WATCH_ENTRY,
  input wire logic SUBACTIVE_ENTRY,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [3:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [3:0] RDATA,
  input wire logic [3:0] ROW_TONE_OUT,
  input wire logic [3:0] COLUMN_TONE_OUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // shadow of the control and oscillator select registers, the only way to know the enables
  logic [3:0] ctl_r, s1_r, s2_r;
  logic lp, known, row_on, col_on;
  assign lp = STOP_ENTRY | WATCH_ENTRY | SUBACTIVE_ENTRY;
  assign known = !(s2_r[3:2] == 2'b10 && {s2_r[3:2], s1_r[1:0]} != 4'hb);
  assign row_on = ctl_r[2] & ctl_r[1];
  assign col_on = ctl_r[3] & ctl_r[1];
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ctl_r <= 4'h0;
      s1_r <= 4'h0;
      s2_r <= 4'h0;
    end
    else if (CLK_EN)
    begin
      if (lp)
        ctl_r <= 4'h0;
      else if (WR && ADDR == 8'h1a)
        ctl_r <= WDATA & 4'he;
      if (STOP_ENTRY)
        s1_r <= {s1_r[3], 3'h0};
      else if (WR && ADDR == 8'h29)
        s1_r <= WDATA;
      if (STOP_ENTRY)
        s2_r <= 4'h0;
      else if (WR && ADDR == 8'h2a)
        s2_r <= WDATA;
    end
  end
  property p_wo_read;
    CLK_EN && RD && ADDR inside {8'h19, 8'h1a, 8'h29, 8'h2a} |=> RDATA == 4'h0;
  endproperty
  a_wo_read: assert property (p_wo_read)
    else $error("write-only register read back non-zero");
  property p_st_en;
    CLK_EN && RD && ADDR == 8'h30 |=> RDATA[1] == $past(ctl_r[1]);
  endproperty
  a_st_en: assert property (p_st_en)
    else $error("status enable bit wrong");
  property p_st_osc;
    CLK_EN && RD && ADDR == 8'h30 |=> RDATA[0] == $past(known);
  endproperty
  a_st_osc: assert property (p_st_osc)
    else $error("status oscillator code bit wrong");
  property p_row_idle;
    !row_on && !$past(row_on) |-> ROW_TONE_OUT == 4'h8;
  endproperty
  a_row_idle: assert property (p_row_idle)
    else $error("row output not idle");
  property p_col_idle;
    !col_on && !$past(col_on) |-> COLUMN_TONE_OUT == 4'h8;
  endproperty
  a_col_idle: assert property (p_col_idle)
    else $error("column output not idle");
  property p_start;
    $rose(row_on) |-> ##[0:2] ROW_TONE_OUT == dtg_pkg::DTG_SINE[0];
  endproperty
  a_start: assert property (p_start)
    else $error("row tone did not start at step zero");
  property p_lp_clr;
    CLK_EN && lp |-> ##2 (ROW_TONE_OUT == 4'h8 && COLUMN_TONE_OUT == 4'h8);
  endproperty
  a_lp_clr: assert property (p_lp_clr)
    else $error("outputs still active after low-power entry");
  // fastest column step is seven reference ticks at ratio one
  property p_step_hold;
    $changed(COLUMN_TONE_OUT) && col_on |=> (!col_on || $stable(COLUMN_TONE_OUT)) [*6];
  endproperty
  a_step_hold: assert property (p_step_hold)
    else $error("column step shorter than its divider allows");
  c_row: cover property ($rose(row_on));
  c_lp: cover property (lp && ctl_r[1]);
  c_st: cover property (RD && ADDR == 8'h30 && !known);
endmodule

bind dtg_top dtg_top_props #(.ADDR_W(ADDR_W)) u_props (.CLK(CLK), .RESET_N(RESET_N),
  .CLK_EN(CLK_EN), .OSC_TICK(OSC_TICK), .STOP_ENTRY(STOP_ENTRY), .WATCH_ENTRY(WATCH_ENTRY),
  .SUBACTIVE_ENTRY(SUBACTIVE_ENTRY), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .ROW_TONE_OUT(ROW_TONE_OUT), .COLUMN_TONE_OUT(COLUMN_TONE_OUT));

// file: sim/dtg_top_tb_top.sv
// self-checking bench for the dual tone generator
`timescale 1ns/100ps
module dtg_top_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0, arm = 1'b0, chan;
  logic ce = 1'b1, osc = 1'b1, half = 1'b0;
  logic [2:0] lp = 3'h0;
  logic [7:0] addr = 8'h00;
  logic [3:0] wdata = 4'h0;
  logic [3:0] rdata, row_out, col_out;
  logic rwrap, cwrap;
  logic [3:0] rq[$];
  int pe[$], pt[$];
  int errors = 0, num_checks = 0, cyc = 0, t0 = 0;
  logic [31:0] seed = 32'd42619;
  logic [3:0] oc[7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hb, 4'h4, 4'hc};
  int orr[7] = '{1, 2, 5, 10, 20, 9, 18};
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  dtg_top uut (.CLK(clk), .RESET_N(rst_n), .CLK_EN(ce), .OSC_TICK(osc),
    .STOP_ENTRY(lp[0]), .WATCH_ENTRY(lp[1]), .SUBACTIVE_ENTRY(lp[2]), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .ROW_TONE_OUT(row_out),
    .COLUMN_TONE_OUT(col_out));
  dtg_line_rx u_rrx (.clk(clk), .tone(row_out), .wrap(rwrap));
  dtg_line_rx u_crx (.clk(clk), .tone(col_out), .wrap(cwrap));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic bad(input int got, exp);
    errors++;
    $display("ERROR %0t got %h exp %h", $time, got, exp);
  endtask
  task automatic cmp_rd(input logic [3:0] got, exp);
    num_checks++;
    if (got !== exp)
      bad(got, exp);
  endtask
  task automatic cmp_per(input int got, exp, tol);
    num_checks++;
    if (got < exp - tol || got > exp + tol)
      bad(got, exp);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [3:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [3:0] e);
    rq.push_back(e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge clk);
    lp <= m;
    @(posedge clk);
    lp <= 3'h0;
  endtask
  // one full sine period is 32 steps of per/16 reference ticks, r cycles each
  task automatic meas(input logic ws, input logic [3:0] sel, ctl, input int per, r);
    int n;
    if (ws)
      wr_reg(8'h19, sel);
    pe.push_back(2 * per * r);
    // output lags the enable write by two cycles; a half-rate oscillator shifts it by one
    pt.push_back(3);
    chan = ctl[3] & ~ctl[2];
    wr_reg(8'h1a, ctl);
    t0 = cyc;
    arm = 1'b1;
    n = 0;
    while (arm && n < 15000)
    begin
      @(posedge clk);
      n++;
    end
    if (arm)
    begin
      // no period end seen in time: counts as a mismatch
      arm = 1'b0;
      num_checks++;
      bad(n, pe.pop_front());
      void'(pt.pop_front());
    end
    wr_reg(8'h1a, 4'h0);
    // let the step spacing check see the stop before the next start
    repeat (8) @(posedge clk);
  endtask
  // ****************************************
  // result watcher and time limit
  // ****************************************
  always @(posedge clk)
  begin
    rd_q <= rd;
    // slow oscillator: one tick every second clock
    osc <= half ? ~osc : 1'b1;
    cyc <= cyc + 1;
    if (cyc == 70000)
    begin
      errors++;
      complete_run();
    end
  end
  always @(negedge clk)
  begin
    if (rd_q)
      cmp_rd(rdata, rq.pop_front());
    if (arm && (chan ? cwrap : rwrap) === 1'b1)
    begin
      arm = 1'b0;
      cmp_per(cyc - t0, pe.pop_front(), pt.pop_front());
    end
  end
  initial
  begin
    logic [7:0] x, a;
    int p;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++)
      rd_reg(8'h19 + 8'(i / 2) * 8'h10 + 8'(i % 2), 4'h0);
    for (int i = 0; i < 6; i++)
    begin
      a = rnd();
      if (a inside {8'h19, 8'h1a, 8'h29, 8'h2a, 8'h30})
        a = a ^ 8'h80;
      x = rnd();
      wr_reg(a, x[3:0]);
      rd_reg(a, 4'h0);
    end
    rd_reg(8'h30, 4'h1);
    $display("test reset and unmapped done");
    for (int i = 0; i < 8; i++)
    begin
      x = rnd();
      p = (i < 4) ? int'(dtg_pkg::DTG_ROW_PER[i]) : int'(dtg_pkg::DTG_COL_PER[i - 4]);
      meas(1'b1, (i < 4) ? {x[1:0], 2'(i)} : {2'(i - 4), x[1:0]},
        (i < 2) ? 4'h6 : ((i < 4) ? 4'he : 4'ha), p, 1);
    end
    $display("test tone codes done");
    for (int i = 0; i < 7; i++)
    begin
      x = rnd();
      wr_reg(8'h29, {x[3:2], oc[i][1:0]});
      wr_reg(8'h2a, {oc[i][3:2], x[1:0]});
      rd_reg(8'h30, 4'h1);
      meas(1'b1, 4'hc, 4'ha, int'(dtg_pkg::DTG_COL_PER[3]), orr[i]);
    end
    $display("test oscillator codes done");
    wr_reg(8'h29, 4'h8);
    wr_reg(8'h2a, 4'h8);
    wr_reg(8'h19, 4'hf);
    wr_reg(8'h1a, 4'he);
    rd_reg(8'h30, 4'he);
    pulse(3'h2);
    rd_reg(8'h30, 4'h0);
    meas(1'b0, 4'h0, 4'ha, int'(dtg_pkg::DTG_COL_PER[0]), 20);
    wr_reg(8'h19, 4'hf);
    pulse(3'h4);
    meas(1'b0, 4'h0, 4'h6, int'(dtg_pkg::DTG_ROW_PER[0]), 20);
    wr_reg(8'h1a, 4'he);
    pulse(3'h1);
    rd_reg(8'h30, 4'h1);
    repeat (4) @(posedge clk);
    $display("test low power entry done");
    // reset in mid-run with an unknown oscillator code and a running generator
    wr_reg(8'h2a, 4'h8);
    wr_reg(8'h1a, 4'he);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(8'h30, 4'h1);
    // a write while the clock enable is low must not be taken
    ce <= 1'b0;
    wr_reg(8'h1a, 4'he);
    ce <= 1'b1;
    rd_reg(8'h30, 4'h1);
    half <= 1'b1;
    meas(1'b1, 4'hc, 4'ha, int'(dtg_pkg::DTG_COL_PER[3]), 2);
    $display("test reset, clock enable and slow oscillator done");
    complete_run();
  end
endmodule
